// File: atc_consts.vh
`ifndef ATC_CONSTS_VH
`define ATC_CONSTS_VH

// Bank offsets in table 02h
`define ATC_TBL_CONFIG        8'h02
`define ATC_OFF_STEP          8'hBB
`define ATC_OFF_HTRIP         8'hBC
`define ATC_OFF_LTRIP         8'hBD
`define ATC_OFF_LOSHI         8'hBE
`define ATC_OFF_LOSLO         8'hBF
`define ATC_OFF_ENFIRST       8'hC0
`define ATC_OFF_ENSECOND      8'hC1

// Reset values
`define ATC_RST_STEP          8'h00
`define ATC_RST_HTRIP         8'h00
`define ATC_RST_LTRIP         8'h00
`define ATC_RST_LOSHI         8'h00
`define ATC_RST_LOSLO         8'h00
`define ATC_RST_ENFIRST       8'h10
`define ATC_RST_ENSECOND      8'h03

// First enable byte fields
`define ATC_EA_TBL78          7
`define ATC_EA_TBL1TOP        6
`define ATC_EA_TBL2           5
`define ATC_EA_TBL1LOW        4
`define ATC_EA_TBL1MID        3
`define ATC_EA_LOWER          2
`define ATC_EA_AUXLO          1
`define ATC_EA_AUXHI          0

// Second enable byte fields
`define ATC_EB_TBL46          7
`define ATC_EB_RD1TOP         6
`define ATC_EB_RD2            5
`define ATC_EB_RD1LOW         4
`define ATC_EB_RD1MID         3
`define ATC_EB_PW1WR          2
`define ATC_EB_AUXLOU         1
`define ATC_EB_AUXHIU         0

// Memory areas
`define ATC_TBL_ONE           8'h01
`define ATC_TBL_FOUR          8'h04
`define ATC_TBL_FIVE          8'h05
`define ATC_TBL_SIX           8'h06
`define ATC_TBL_SEVEN         8'h07
`define ATC_TBL_EIGHT         8'h08
`define ATC_LOWER_TOP         8'h5F
`define ATC_UPPER_BASE        8'h80
`define ATC_T1_LOW_TOP        8'hBF
`define ATC_T1_MID_TOP        8'hF7
`define ATC_PWONE_FIRST       8'hB0
`define ATC_PWONE_LAST        8'hB3

// Power loop constants
`define ATC_CODE_MAX          8'hFF
`define ATC_CODE_MIN          8'h00
`define ATC_STEP_DIV          16'd40

`endif

// File: atc_access_check.v
`timescale 1ns/1ps
`include "atc_consts.vh"

module atc_access_check
(
   // Access request
   input  wire [7:0] reqTable,
   input  wire [7:0] reqAddr,
   input  wire       reqAux,
   input  wire       maskSel,
   // Password state and enables
   input  wire       pwLevelOne,
   input  wire       pwLevelTwo,
   input  wire [7:0] enFirst,
   input  wire [7:0] enSecond,
   // Verdict
   output reg        readOk,
   output reg        writeOk
);

   // Level two always; level one via read-write or read-only enable
   function rdGrant;
      input p1;
      input p2;
      input rw;
      input ro;
      begin
         rdGrant = p2 | (p1 & (rw | ro));
      end
   endfunction

   function wrGrant;
      input p1;
      input p2;
      input rw;
      begin
         wrGrant = p2 | (p1 & rw);
      end
   endfunction

   wire upperTop = (reqAddr > `ATC_T1_MID_TOP);
   wire topTable = maskSel ? (reqTable == `ATC_TBL_FIVE) : (reqTable == `ATC_TBL_ONE);

   always @*
   begin
      readOk  = pwLevelTwo;
      writeOk = pwLevelTwo;
      if (reqAux)
      begin
         readOk = 1'b1;
         if (reqAddr < `ATC_UPPER_BASE)
            writeOk = wrGrant(pwLevelOne, pwLevelTwo, enFirst[`ATC_EA_AUXLO])
                      | enSecond[`ATC_EB_AUXLOU];
         else
            writeOk = wrGrant(pwLevelOne, pwLevelTwo, enFirst[`ATC_EA_AUXHI])
                      | enSecond[`ATC_EB_AUXHIU];
      end
      else if (reqAddr <= `ATC_LOWER_TOP)
      begin
         readOk  = 1'b1;
         writeOk = wrGrant(pwLevelOne, pwLevelTwo, enFirst[`ATC_EA_LOWER]);
      end
      else if (reqAddr < `ATC_UPPER_BASE)
      begin
         readOk  = 1'b1;
         writeOk = pwLevelTwo;
      end
      else if (upperTop && topTable)
      begin
         readOk  = rdGrant(pwLevelOne, pwLevelTwo, enFirst[`ATC_EA_TBL1TOP],
                           enSecond[`ATC_EB_RD1TOP]);
         writeOk = wrGrant(pwLevelOne, pwLevelTwo, enFirst[`ATC_EA_TBL1TOP]);
      end
      else if (reqTable == `ATC_TBL_ONE && !upperTop)
      begin
         if (reqAddr <= `ATC_T1_LOW_TOP)
         begin
            readOk  = rdGrant(pwLevelOne, pwLevelTwo, enFirst[`ATC_EA_TBL1LOW],
                              enSecond[`ATC_EB_RD1LOW]);
            writeOk = wrGrant(pwLevelOne, pwLevelTwo, enFirst[`ATC_EA_TBL1LOW]);
         end
         else
         begin
            readOk  = rdGrant(pwLevelOne, pwLevelTwo, enFirst[`ATC_EA_TBL1MID],
                              enSecond[`ATC_EB_RD1MID]);
            writeOk = wrGrant(pwLevelOne, pwLevelTwo, enFirst[`ATC_EA_TBL1MID]);
         end
      end
      else if (reqTable == `ATC_TBL_CONFIG)
      begin
         if (reqAddr >= `ATC_PWONE_FIRST && reqAddr <= `ATC_PWONE_LAST)
         begin
            readOk  = 1'b0;
            writeOk = wrGrant(pwLevelOne, pwLevelTwo, enSecond[`ATC_EB_PW1WR]);
         end
         else
         begin
            readOk  = rdGrant(pwLevelOne, pwLevelTwo, enFirst[`ATC_EA_TBL2],
                              enSecond[`ATC_EB_RD2]);
            writeOk = wrGrant(pwLevelOne, pwLevelTwo, enFirst[`ATC_EA_TBL2]);
         end
      end
      else if (reqTable == `ATC_TBL_FOUR || reqTable == `ATC_TBL_SIX)
      begin
         readOk  = wrGrant(pwLevelOne, pwLevelTwo, enSecond[`ATC_EB_TBL46]);
         writeOk = wrGrant(pwLevelOne, pwLevelTwo, enSecond[`ATC_EB_TBL46]);
      end
      else if (reqTable == `ATC_TBL_SEVEN || reqTable == `ATC_TBL_EIGHT)
      begin
         readOk  = wrGrant(pwLevelOne, pwLevelTwo, enFirst[`ATC_EA_TBL78]);
         writeOk = wrGrant(pwLevelOne, pwLevelTwo, enFirst[`ATC_EA_TBL78]);
      end
   end

endmodule

// File: atc_trip_config.v
`timescale 1ns/1ps
`include "atc_consts.vh"

module atc_trip_config
#(
   parameter BIAS_W   = 10,
   parameter STEP_DIV = `ATC_STEP_DIV
)
(
   // Clock and reset
   input  wire              clk_sys,
   input  wire              arst_n,
   // Host transaction port
   input  wire [7:0]        hostTable,
   input  wire [7:0]        hostAddr,
   input  wire              hostAux,
   input  wire              hostRead,
   input  wire              hostWrite,
   input  wire [7:0]        hostWrData,
   output reg  [7:0]        hostRdData,
   output reg               hostDone,
   output reg               hostDenied,
   // Password state
   input  wire              pwLevelOne,
   input  wire              pwLevelTwo,
   input  wire              maskSel,
   // Power loop inputs
   input  wire              txDisablePulse,
   input  wire [7:0]        powerFeedback,
   input  wire [7:0]        loopReference,
   input  wire [7:0]        maximumBiasLimit,
   input  wire [7:0]        signalStrength,
   // Loop and alarm outputs
   output reg  [BIAS_W-1:0] biasValue,
   output reg               loopRunning,
   output reg               maximumBiasAlarm,
   output reg               transmitPowerHighAlarm,
   output reg               transmitPowerLowAlarm,
   output reg               signalLossLowAlarm,
   output reg               signalLossHighAlarm,
   // Enable bytes for the rest of the device
   output wire [7:0]        accessEnableFirst,
   output wire [7:0]        accessEnableSecond
);

   localparam [3:0] ST_STEP   = 4'h1;
   localparam [3:0] ST_SEARCH = 4'h2;
   localparam [3:0] ST_RUN    = 4'h4;
   localparam [3:0] ST_IDLE   = 4'h8;

   reg  [7:0]        initialBiasStep_r;
   reg  [7:0]        highPowerTripAdjust_r;
   reg  [7:0]        lowPowerTripAdjust_r;
   reg  [7:0]        lossHighThreshold_r;
   reg  [7:0]        lossLowThreshold_r;
   reg  [7:0]        accessEnableFirst_r;
   reg  [7:0]        accessEnableSecond_r;
   reg  [3:0]        state_r;
   reg  [3:0]        state_nxt;
   reg  [BIAS_W-1:0] bias_nxt;
   reg  [BIAS_W-1:0] trialBit_r;
   reg  [BIAS_W-1:0] trialBit_nxt;
   reg  [15:0]       divCnt_r;
   reg               tick_r;
   reg               alarmArm_r;
   reg               clampHit;
   wire              readOk;
   wire              writeOk;
   wire              inBank;
   wire [8:0]        highSum;
   wire [8:0]        lowDiff;
   wire [7:0]        highTripCode;
   wire [7:0]        lowTripCode;
   wire [BIAS_W:0]   stepSum;
   wire [BIAS_W-1:0] biasCeil;
   wire              feedbackHigh;

   assign accessEnableFirst  = accessEnableFirst_r;
   assign accessEnableSecond = accessEnableSecond_r;

   // Bias ceiling: limit sets the upper eight bits
   function [BIAS_W-1:0] ceilOf;
      input [7:0] lim;
      begin
         ceilOf = {lim, {(BIAS_W-8){1'b1}}};
      end
   endfunction

   assign biasCeil     = ceilOf(maximumBiasLimit);
   assign feedbackHigh = (powerFeedback > loopReference);

   atc_access_check uAccess
   (
      .reqTable   (hostTable),
      .reqAddr    (hostAddr),
      .reqAux     (hostAux),
      .maskSel    (maskSel),
      .pwLevelOne (pwLevelOne),
      .pwLevelTwo (pwLevelTwo),
      .enFirst    (accessEnableFirst_r),
      .enSecond   (accessEnableSecond_r),
      .readOk     (readOk),
      .writeOk    (writeOk)
   );

   assign inBank = !hostAux && (hostTable == `ATC_TBL_CONFIG) &&
                   (hostAddr >= `ATC_OFF_STEP) && (hostAddr <= `ATC_OFF_ENSECOND);

   // Register bank writes and read answers
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         initialBiasStep_r     <= `ATC_RST_STEP;
         highPowerTripAdjust_r <= `ATC_RST_HTRIP;
         lowPowerTripAdjust_r  <= `ATC_RST_LTRIP;
         lossHighThreshold_r   <= `ATC_RST_LOSHI;
         lossLowThreshold_r    <= `ATC_RST_LOSLO;
         accessEnableFirst_r   <= `ATC_RST_ENFIRST;
         accessEnableSecond_r  <= `ATC_RST_ENSECOND;
         hostRdData            <= 8'h00;
         hostDone              <= 1'b0;
         hostDenied            <= 1'b0;
      end
      else
      begin
         hostDone   <= hostRead | hostWrite;
         hostDenied <= (hostRead & !readOk) | (hostWrite & !writeOk);
         if (hostRead)
         begin
            hostRdData <= 8'h00;
            if (inBank && readOk)
            begin
               case (hostAddr)
                  `ATC_OFF_STEP:     hostRdData <= initialBiasStep_r;
                  `ATC_OFF_HTRIP:    hostRdData <= highPowerTripAdjust_r;
                  `ATC_OFF_LTRIP:    hostRdData <= lowPowerTripAdjust_r;
                  `ATC_OFF_LOSHI:    hostRdData <= lossHighThreshold_r;
                  `ATC_OFF_LOSLO:    hostRdData <= lossLowThreshold_r;
                  `ATC_OFF_ENFIRST:  hostRdData <= accessEnableFirst_r;
                  `ATC_OFF_ENSECOND: hostRdData <= accessEnableSecond_r;
                  default:           hostRdData <= 8'h00;
               endcase
            end
         end
         else if (hostWrite && inBank && writeOk)
         begin
            case (hostAddr)
               `ATC_OFF_STEP:     initialBiasStep_r     <= hostWrData;
               `ATC_OFF_HTRIP:    highPowerTripAdjust_r <= hostWrData;
               `ATC_OFF_LTRIP:    lowPowerTripAdjust_r  <= hostWrData;
               `ATC_OFF_LOSHI:    lossHighThreshold_r   <= hostWrData;
               `ATC_OFF_LOSLO:    lossLowThreshold_r    <= hostWrData;
               `ATC_OFF_ENFIRST:
               begin
                  accessEnableFirst_r <= hostWrData;
                  if (!pwLevelTwo)
                     accessEnableFirst_r[`ATC_EA_TBL2] <=
                        accessEnableFirst_r[`ATC_EA_TBL2];
               end
               `ATC_OFF_ENSECOND: accessEnableSecond_r  <= hostWrData;
               default:           accessEnableSecond_r  <= accessEnableSecond_r;
            endcase
         end
      end
   end

   // Loop update rate
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         divCnt_r <= 16'h0000;
         tick_r   <= 1'b0;
      end
      else if (divCnt_r >= STEP_DIV - 16'h0001)
      begin
         divCnt_r <= 16'h0000;
         tick_r   <= 1'b1;
      end
      else
      begin
         divCnt_r <= divCnt_r + 16'h0001;
         tick_r   <= 1'b0;
      end
   end

   assign stepSum = {1'b0, biasValue} + {1'b0, initialBiasStep_r, {(BIAS_W-8){1'b0}}}
                    + {{BIAS_W{1'b0}}, 1'b1};

   // Startup stepping, search and closed loop
   always @*
   begin
      state_nxt    = state_r;
      bias_nxt     = biasValue;
      trialBit_nxt = trialBit_r;
      clampHit     = 1'b0;
      case (state_r)
         ST_STEP:
         begin
            if (feedbackHigh)
            begin
               state_nxt    = ST_SEARCH;
               bias_nxt     = {1'b1, {(BIAS_W-1){1'b0}}};
               trialBit_nxt = {1'b1, {(BIAS_W-1){1'b0}}};
            end
            else if (stepSum[BIAS_W] || stepSum[BIAS_W-1:0] > biasCeil)
            begin
               state_nxt    = ST_SEARCH;
               bias_nxt     = {1'b1, {(BIAS_W-1){1'b0}}};
               trialBit_nxt = {1'b1, {(BIAS_W-1){1'b0}}};
            end
            else
               bias_nxt = stepSum[BIAS_W-1:0];
         end
         ST_SEARCH:
         begin
            if (feedbackHigh || biasValue > biasCeil)
               bias_nxt = biasValue & ~trialBit_r;
            trialBit_nxt = trialBit_r >> 1;
            if (trialBit_r[0])
               state_nxt = ST_RUN;
            else
               bias_nxt = (feedbackHigh || biasValue > biasCeil ?
                           biasValue & ~trialBit_r : biasValue) | (trialBit_r >> 1);
         end
         ST_RUN:
         begin
            if (feedbackHigh)
            begin
               if (biasValue != {BIAS_W{1'b0}})
                  bias_nxt = biasValue - {{(BIAS_W-1){1'b0}}, 1'b1};
            end
            else if (powerFeedback < loopReference)
            begin
               if (biasValue >= biasCeil)
               begin
                  bias_nxt = biasCeil;
                  clampHit = 1'b1;
               end
               else
                  bias_nxt = biasValue + {{(BIAS_W-1){1'b0}}, 1'b1};
            end
         end
         default:
            state_nxt = ST_STEP;
      endcase
   end

   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r          <= ST_IDLE;
         biasValue        <= {BIAS_W{1'b0}};
         trialBit_r       <= {BIAS_W{1'b0}};
         alarmArm_r       <= 1'b0;
         loopRunning      <= 1'b0;
         maximumBiasAlarm <= 1'b0;
      end
      else if (txDisablePulse)
      begin
         state_r          <= ST_STEP;
         biasValue        <= {BIAS_W{1'b0}};
         trialBit_r       <= {BIAS_W{1'b0}};
         alarmArm_r       <= 1'b0;
         loopRunning      <= 1'b0;
         maximumBiasAlarm <= 1'b0;
      end
      else if (tick_r)
      begin
         state_r     <= state_nxt;
         biasValue   <= bias_nxt;
         trialBit_r  <= trialBit_nxt;
         loopRunning <= (state_nxt == ST_RUN);
         if (state_r == ST_SEARCH && state_nxt == ST_RUN)
            alarmArm_r <= 1'b1;
         maximumBiasAlarm <= alarmArm_r && clampHit;
      end
   end

   // Trip codes
   assign highSum      = {1'b0, loopReference} + {1'b0, highPowerTripAdjust_r};
   assign highTripCode = highSum[8] ? `ATC_CODE_MAX : highSum[7:0];
   assign lowDiff      = {1'b0, loopReference} - {1'b0, lowPowerTripAdjust_r};
   assign lowTripCode  = lowDiff[8] ? `ATC_CODE_MIN : lowDiff[7:0];

   // Power alarms and loss hysteresis
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         transmitPowerHighAlarm <= 1'b0;
         transmitPowerLowAlarm  <= 1'b0;
         signalLossLowAlarm     <= 1'b0;
         signalLossHighAlarm    <= 1'b0;
      end
      else
      begin
         transmitPowerHighAlarm <= (powerFeedback > highTripCode);
         transmitPowerLowAlarm  <= (powerFeedback < lowTripCode);
         if (!signalLossLowAlarm)
         begin
            if (signalStrength < lossLowThreshold_r)
            begin
               signalLossLowAlarm  <= 1'b1;
               signalLossHighAlarm <= 1'b0;
            end
         end
         else if (signalStrength > lossHighThreshold_r)
         begin
            signalLossLowAlarm  <= 1'b0;
            signalLossHighAlarm <= 1'b1;
         end
      end
   end

endmodule

// File: atc_trip_config_chk.sv
`timescale 1ns/1ps
module atc_trip_config_chk
#(
   parameter BIAS_W = 10
)
(
   // Clock and reset
   input wire              clk_sys,
   input wire              arst_n,
   // Host port
   input wire              hostRead,
   input wire              hostWrite,
   input wire [7:0]        hostRdData,
   input wire              hostDone,
   input wire              hostDenied,
   // Loop inputs
   input wire              txDisablePulse,
   input wire [7:0]        powerFeedback,
   input wire [7:0]        loopReference,
   input wire [7:0]        maximumBiasLimit,
   // Loop, alarm and enable outputs
   input wire [BIAS_W-1:0] biasValue,
   input wire              loopRunning,
   input wire              maximumBiasAlarm,
   input wire              transmitPowerHighAlarm,
   input wire              transmitPowerLowAlarm,
   input wire              signalLossLowAlarm,
   input wire              signalLossHighAlarm,
   input wire [7:0]        accessEnableFirst
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   a_done_after_req: assert property ((hostRead || hostWrite) |=> hostDone)
      else $error("no done after request");
   a_done_needs_req: assert property (hostDone |-> ($past(hostRead) || $past(hostWrite)))
      else $error("done without request");
   a_denied_with_done: assert property (hostDenied |-> hostDone)
      else $error("denied outside done");
   a_rddata_on_read: assert property (!$stable(hostRdData) |-> $past(hostRead))
      else $error("read data moved without read");
   a_enable_on_write: assert property (!$stable(accessEnableFirst) |-> $past(hostWrite))
      else $error("enable byte moved without write");
   a_high_sat_top: assert property (loopReference == 8'hFF |=> !transmitPowerHighAlarm)
      else $error("high alarm above saturated code");
   a_high_over_ref: assert property (transmitPowerHighAlarm |->
      $past(powerFeedback) > $past(loopReference)) else $error("high alarm below trip");
   a_low_clamp_zero: assert property (loopReference == 8'h00 |=> !transmitPowerLowAlarm)
      else $error("low alarm below clamped code");
   a_low_under_ref: assert property (transmitPowerLowAlarm |->
      $past(powerFeedback) < $past(loopReference)) else $error("low alarm above trip");
   a_loss_exclusive: assert property (!(signalLossLowAlarm && signalLossHighAlarm))
      else $error("both loss alarms set");
   a_restart_clears: assert property (txDisablePulse |=> biasValue == 0 && !loopRunning)
      else $error("restart did not clear bias");
   a_alarm_when_run: assert property (maximumBiasAlarm |-> loopRunning)
      else $error("bias alarm during startup");
   a_bias_ceiling: assert property (loopRunning && $stable(maximumBiasLimit) |->
      biasValue <= {maximumBiasLimit, 2'b11}) else $error("bias above ceiling");
endmodule

bind atc_trip_config atc_trip_config_chk #(.BIAS_W(BIAS_W)) chk
(
   .clk_sys, .arst_n, .hostRead, .hostWrite, .hostRdData, .hostDone, .hostDenied,
   .txDisablePulse, .powerFeedback, .loopReference, .maximumBiasLimit, .biasValue,
   .loopRunning, .maximumBiasAlarm, .transmitPowerHighAlarm, .transmitPowerLowAlarm,
   .signalLossLowAlarm, .signalLossHighAlarm, .accessEnableFirst
);

// File: atc_host_model.sv
`timescale 1ns/1ps
module atc_host_model
(
   // Clock and answer
   input  wire        clk_sys,
   input  wire        hostDone,
   input  wire        hostDenied,
   input  wire  [7:0] hostRdData,
   // Request
   output logic [7:0] hostTable,
   output logic [7:0] hostAddr,
   output logic       hostAux,
   output logic       hostRead,
   output logic       hostWrite,
   output logic [7:0] hostWrData
);
   initial
   begin
      hostTable = 8'h00;
      hostAddr = 8'h00;
      hostAux = 1'b0;
      hostRead = 1'b0;
      hostWrite = 1'b0;
      hostWrData = 8'h00;
   end

   task automatic xfer(input logic [7:0] t, a, input logic x, wr, input logic [7:0] d,
                       output logic [7:0] rd, output logic dn, output logic ok);
      int n;
      @(negedge clk_sys);
      hostTable = t;
      hostAddr = a;
      hostAux = x;
      hostWrData = d;
      hostRead = !wr;
      hostWrite = wr;
      @(negedge clk_sys);
      hostRead = 1'b0;
      hostWrite = 1'b0;
      // Stale data must not look valid
      hostWrData = ~d;
      n = 0;
      while (hostDone !== 1'b1 && n < 4)
      begin
         @(negedge clk_sys);
         n++;
      end
      ok = (hostDone === 1'b1);
      rd = hostRdData;
      dn = hostDenied;
   endtask
endmodule

// File: atc_tb.sv
`timescale 1ns/1ps
module testbench;
   logic       clk_sys, arst_n, hostAux, hostRead, hostWrite, hostDone, hostDenied;
   logic [7:0] hostTable, hostAddr, hostWrData, hostRdData, accessEnableFirst;
   logic       pwLevelOne, pwLevelTwo, maskSel, txDisablePulse, loopRunning;
   logic [7:0] powerFeedback, loopReference, maximumBiasLimit, signalStrength;
   logic [9:0] biasValue;
   logic       maximumBiasAlarm, transmitPowerHighAlarm, transmitPowerLowAlarm;
   logic       signalLossLowAlarm, signalLossHighAlarm, den, ok, fbTrack, ax, w, p1, p2, ms;
   logic [7:0] accessEnableSecond, rdv, tbl, ad, ea, eb, r, a, rf, fb, hiT, loT;
   int         fails, compares, i, s;
   logic [7:0] sv [5] = '{8'h00, 8'h80, 8'hD0, 8'h80, 8'h30};
   logic [1:0] le [5] = '{2'b10, 2'b10, 2'b01, 2'b01, 2'b10};
   logic [9:0] st [2][3] = '{'{10'h041, 10'h082, 10'h0C3}, '{10'h041, 10'h082, 10'h200}};

   atc_trip_config #(.BIAS_W(10), .STEP_DIV(16'd4)) dut
   (
      .clk_sys, .arst_n, .hostTable, .hostAddr, .hostAux, .hostRead, .hostWrite,
      .hostWrData, .hostRdData, .hostDone, .hostDenied, .pwLevelOne, .pwLevelTwo, .maskSel,
      .txDisablePulse, .powerFeedback, .loopReference, .maximumBiasLimit, .signalStrength,
      .biasValue, .loopRunning, .maximumBiasAlarm, .transmitPowerHighAlarm,
      .transmitPowerLowAlarm, .signalLossLowAlarm, .signalLossHighAlarm,
      .accessEnableFirst, .accessEnableSecond
   );
   atc_host_model host
   (
      .clk_sys, .hostDone, .hostDenied, .hostRdData, .hostTable, .hostAddr, .hostAux,
      .hostRead, .hostWrite, .hostWrData
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Feedback follows the bias like a simple optical path
   always @(negedge clk_sys)
      if (fbTrack)
         powerFeedback <= biasValue[9:2];

   task automatic complete_run;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic [7:0] t, d2, input logic x, wr, input logic [7:0] d);
      host.xfer(t, d2, x, wr, d, rdv, den, ok);
      if (!ok)
      begin
         fails++;
         complete_run;
      end
   endtask
   task automatic bank(input logic wr, input logic [7:0] d2, d);
      acc(8'h02, d2, 1'b0, wr, d);
   endtask
   task automatic setPw(input logic l1, l2);
      @(negedge clk_sys);
      pwLevelOne = l1;
      pwLevelTwo = l2;
   endtask
   task automatic waitBias(input int lim);
      logic [9:0] b;
      int n;
      b = biasValue;
      n = 0;
      while (biasValue === b && n < lim)
      begin
         @(negedge clk_sys);
         n++;
      end
      if (n == lim)
      begin
         fails++;
         complete_run;
      end
   endtask
   function automatic logic expDeny(input logic [7:0] t, d2, input logic x, wr, l1, l2, m,
                                    input logic [7:0] fa, fb2);
      logic rd, wa;
      int k;
      rd = 1'b1;
      wa = l2;
      k = -1;
      if (x)
         wa = l2 | (l1 & fa[d2[7] ? 0 : 1]) | fb2[d2[7] ? 0 : 1];
      else if (d2 <= 8'h5F)
         wa = l2 | (l1 & fa[2]);
      else if (d2 >= 8'h80)
      begin
         rd = l2;
         if (t == 8'h02 && d2 >= 8'hB0 && d2 <= 8'hB3)
         begin
            rd = 1'b0;
            wa = l2 | (l1 & fb2[2]);
         end
         else if (t == 8'h02)
            k = 5;
         else if (d2 >= 8'hF8 && ((t == 8'h01 && !m) || (t == 8'h05 && m)))
            k = 6;
         else if (t == 8'h01 && d2 < 8'hF8)
            k = (d2 <= 8'hBF) ? 4 : 3;
         else if (t == 8'h04 || t == 8'h06)
            rd = l2 | (l1 & fb2[7]);
         else if (t == 8'h07 || t == 8'h08)
            rd = l2 | (l1 & fa[7]);
         if (t >= 8'h04 && t != 8'h05)
            wa = rd;
         if (k >= 0)
         begin
            rd = l2 | (l1 & (fa[k] | fb2[k]));
            wa = l2 | (l1 & fa[k]);
         end
      end
      return wr ? !wa : !rd;
   endfunction

   initial
   begin
      arst_n = 1'b0;
      {pwLevelOne, pwLevelTwo, maskSel, txDisablePulse, fbTrack} = 5'b01000;
      {powerFeedback, loopReference, maximumBiasLimit, signalStrength} = 32'h0040FF00;
      fails = 0;
      compares = 0;
      void'($urandom(32'h3C61D04E));
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      arst_n = 1'b1;
      chk({signalLossLowAlarm, signalLossHighAlarm, accessEnableFirst, accessEnableSecond},
          24'h001003);
      for (i = 0; i < 7; i++)
      begin
         bank(1'b0, 8'hBB + 8'(i), 8'h00);
         chk({den, rdv}, (i == 5) ? 9'h010 : (i == 6) ? 9'h003 : 9'h000);
      end
      bank(1'b0, 8'hB0, 8'h00);
      chk(den, 1'b1);
      bank(1'b1, 8'hBF, 8'h40);
      bank(1'b1, 8'hBE, 8'hC0);
      for (i = 0; i < 5; i++)
      begin
         @(negedge clk_sys);
         signalStrength = sv[i];
         repeat (2) @(negedge clk_sys);
         chk({signalLossLowAlarm, signalLossHighAlarm}, le[i]);
      end
      r = 8'($urandom);
      bank(1'b1, 8'hBD, r);
      setPw(1'b1, 1'b0);
      bank(1'b1, 8'hBD, ~r);
      chk(den, 1'b1);
      bank(1'b0, 8'hBD, 8'h00);
      chk({den, rdv}, 9'h100);
      setPw(1'b0, 1'b1);
      bank(1'b1, 8'hC1, 8'h23);
      setPw(1'b1, 1'b0);
      bank(1'b0, 8'hBD, 8'h00);
      chk({den, rdv}, {1'b0, r});
      bank(1'b1, 8'hBD, ~r);
      chk(den, 1'b1);
      setPw(1'b0, 1'b1);
      bank(1'b1, 8'hC0, 8'h30);
      setPw(1'b1, 1'b0);
      bank(1'b1, 8'hC0, 8'h00);
      bank(1'b0, 8'hC0, 8'h00);
      chk({den, rdv}, 9'h020);
      bank(1'b1, 8'hBD, ~r);
      bank(1'b0, 8'hBD, 8'h00);
      chk({den, rdv}, {1'b0, ~r});
      for (i = 0; i < 150; i++)
      begin
         ea = 8'($urandom);
         eb = 8'($urandom);
         setPw(1'b0, 1'b1);
         bank(1'b1, 8'hC0, ea);
         bank(1'b1, 8'hC1, eb);
         chk({accessEnableFirst, accessEnableSecond}, {ea, eb});
         tbl = 8'(1 + $urandom % 8);
         ad = 8'($urandom);
         {ax, w, ms, p1, p2} = 5'($urandom);
         ax = ax & ms;
         maskSel = ms;
         setPw(p1, p2);
         acc(tbl, ad, ax, w, 8'($urandom));
         chk(den, expDeny(tbl, ad, ax, w, p1, p2, ms, ea, eb));
      end
      setPw(1'b0, 1'b1);
      for (i = 0; i < 40; i++)
      begin
         {a, r, rf, fb} = $urandom;
         if (i == 0)
            {a, rf, fb} = 24'h20F0FF;
         if (i == 1)
            {r, rf, fb} = 24'h301000;
         bank(1'b1, 8'hBC, a);
         bank(1'b1, 8'hBD, r);
         loopReference = rf;
         powerFeedback = fb;
         hiT = (9'(rf) + 9'(a) > 9'h0FF) ? 8'hFF : rf + a;
         loT = (rf < r) ? 8'h00 : rf - r;
         repeat (2) @(negedge clk_sys);
         chk(transmitPowerHighAlarm, fb > hiT);
         chk(transmitPowerLowAlarm, fb < loT);
      end
      bank(1'b1, 8'hBB, 8'h10);
      loopReference = 8'h40;
      fbTrack = 1'b1;
      for (s = 0; s < 2; s++)
      begin
         @(negedge clk_sys);
         maximumBiasLimit = s ? 8'h20 : 8'hFF;
         txDisablePulse = 1'b1;
         @(negedge clk_sys);
         txDisablePulse = 1'b0;
         for (i = 0; i < 3; i++)
         begin
            waitBias(12);
            chk(biasValue, st[s][i]);
         end
         while (!loopRunning && i < 3000)
         begin
            @(negedge clk_sys);
            i++;
         end
         if (!loopRunning)
         begin
            fails++;
            complete_run;
         end
         repeat (40) @(negedge clk_sys);
         chk({loopRunning, maximumBiasAlarm, biasValue[9:3]}, {1'b1, s[0], s ? 7'h10 : 7'h20});
      end
      complete_run;
   end
endmodule
